// *** verilog/msc_regs.vh ***
// register offsets, status fields, task codes and coding constants for the status/crc/fec block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef MSC_REGS_VH
`define MSC_REGS_VH
// byte offsets
`define MSC_OFF_STATUS    12'h000
`define MSC_OFF_QUALITY   12'h004
`define MSC_OFF_COMMAND   12'h008
`define MSC_OFF_MODE      12'h00C
`define MSC_OFF_CRC       12'h010
`define MSC_OFF_FEC       12'h014
// status bit positions
`define MSC_ST_IRQ        7
`define MSC_ST_IBE        5
`define MSC_ST_OVF        4
`define MSC_ST_CHK        3
`define MSC_ST_QRDY       2
`define MSC_ST_ORIG       1
// mode bit positions
`define MSC_MD_TXRX       5
`define MSC_MD_POWER_SAVE_BIT      3
`define MSC_MD_QIEN       2
`define MSC_MODE_RESET    8'h00
// task codes
`define MSC_TASK_NULL     4'h0
`define MSC_TASK_SFH      4'h1
`define MSC_TASK_R3H      4'h2
`define MSC_TASK_RDB      4'h3
`define MSC_TASK_SFS      4'h4
`define MSC_TASK_T7H      4'h5
`define MSC_TASK_TDB      4'h6
`define MSC_TASK_TSO      4'h7
`define MSC_TASK_RESET    4'h8
// coding constants
`define MSC_CRC_POLY      16'h1021
`define MSC_CRC_INIT      16'hFFFF
`define MSC_FEC_ROW0      8'hEC
`define MSC_FEC_ROW1      8'hD3
`define MSC_FEC_ROW2      8'hBA
`define MSC_FEC_ROW3      8'h75
`define MSC_BLOCK_BYTES   5'h12
`define MSC_QUAL_BITS     8'hF0
`define MSC_ORIG_MOBILE   3'h3
`endif

// *** verilog/msc_status_crc_fec.v ***
// status flags, data quality, crc and fec coding for the packet modem
// assumes a synchronous apb master and bit-rate events from the modem core
// assumes every event input is a one-cycle pulse, tx_buffer_low may be a level
// assumes a zero-wait slave suits the host: reads are answered in the access cycle
//
// Contract
// - tx: buffer low sets empty flag, irq only on its rise
// - reset task or mode change sets empty flag
// - real task write clears empty flag
// - rx: late task sets overflow and irq
// - status read, reset, mode change clear overflow
// - rx: check flag updated after crc/fec
// - reset or mode change clears check; tx zero
// - quality ready set on reading, cleared on read
// - after reset/mode-to-zero quality ready may set
// - origin flag from preamble, one error allowed
// - bit zero reads zero; origin zero in tx
// - average zero-crossing over 240 bits, 0-240
// - measurement restarts at end of search tasks
// - quality register reads zero in transmit
// - crc16 over 18 bytes, x16+x12+x5+1
// - preset ones, lsb first, inverted, msb out
// - receive crc compare, mismatch flags error
// - four fec parities from byte and masks
// - first mask parity is fec msb
// - receive syndrome from full 12-bit rows
// - correct single error per 12-bit word
// - interrupt flag cleared by status read
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.vh"
module msc_status_crc_fec #(
   parameter QUAL_BITS = 240
) (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   // modem core events
   input  wire        tx_buffer_low,
   input  wire        rx_task_late,
   input  wire        task_done,
   input  wire [3:0]  done_task,
   input  wire        head_check_done,
   input  wire [2:0]  presync_bits,
   input  wire        rx_bit_strobe,
   input  wire        rx_bit_good,
   // coding data path, task and interrupt outputs
   input  wire        crc_byte_valid,
   input  wire [7:0]  crc_byte,
   input  wire        crc_start,
   input  wire        crc_check,
   input  wire [15:0] crc_received,
   input  wire [7:0]  fec_tx_byte,
   input  wire [11:0] fec_rx_word,
   input  wire        fec_rx_valid,
   output reg  [3:0]  fec_tx_nibble,
   output reg  [7:0]  fec_rx_byte,
   output reg         fec_rx_error,
   output reg  [15:0] crc_out,
   output wire [2:0]  current_task,
   output wire        irq_flag
);
   // registers
   reg  [7:0]  mode_reg;      // written mode bits
   reg  [3:0]  task_reg;      // last written task
   reg         irq_reg;       // interrupt flag
   reg         ibe_reg;       // interleave empty flag
   reg         ovf_reg;       // deinterleave overflow flag
   reg         chk_reg;       // check error flag
   reg         qrdy_reg;      // quality ready flag
   reg         orig_reg;      // origin flag
   reg  [7:0]  qual_reg;      // quality value
   reg  [7:0]  qcnt_reg;      // bits counted so far
   reg  [7:0]  qacc_reg;      // good bits so far
   reg  [15:0] crc_reg;       // running crc
   reg  [4:0]  crc_cnt_reg;   // bytes taken
   // decoded bus strobes
   wire        acc     = psel & penable;
   wire        wr      = acc & pwrite;
   wire        rd      = acc & ~pwrite;
   // register selects for writes with side effects
   wire        wr_cmd  = wr & (paddr == `MSC_OFF_COMMAND);
   wire        wr_mode = wr & (paddr == `MSC_OFF_MODE);
   // reads with side effects: status clears irq and overflow, quality clears ready
   wire        rd_stat = rd & (paddr == `MSC_OFF_STATUS);
   wire        rd_qual = rd & (paddr == `MSC_OFF_QUALITY);
   // task code on the bus and current direction
   wire [3:0]  wtask   = pwdata[3:0];
   wire        tx_mode = mode_reg[`MSC_MD_TXRX];
   // reset task flushes the flags like a mode change does
   wire        rst_task = wr_cmd & (wtask == `MSC_TASK_RESET);
   // change of mode select or power save
   wire        mode_chg = wr_mode &
                  ((pwdata[`MSC_MD_TXRX] != mode_reg[`MSC_MD_TXRX]) |
                   (pwdata[`MSC_MD_POWER_SAVE_BIT] != mode_reg[`MSC_MD_POWER_SAVE_BIT]));
   wire        mode_to0 = mode_chg & ~pwdata[`MSC_MD_TXRX] & ~pwdata[`MSC_MD_POWER_SAVE_BIT];
   wire        flush    = rst_task | mode_chg;
   // a task that actually starts work
   wire        real_task = wr_cmd & (wtask != `MSC_TASK_NULL) &
                  (wtask != `MSC_TASK_RESET) & (wtask != `MSC_TASK_TSO);
   // search and receive tasks realign the quality window
   wire        meas_restart = task_done & ((done_task == `MSC_TASK_SFS) |
                  (done_task == `MSC_TASK_SFH) | (done_task == `MSC_TASK_RDB) |
                  (done_task == `MSC_TASK_R3H));
   // last bit of the quality window; the count runs from zero to QUAL_BITS-1
   wire        qual_done = ~tx_mode & rx_bit_strobe & (qcnt_reg == QUAL_BITS[7:0] - 8'h01);
   // bits that differ from the mobile pattern; base is its complement, so
   // one bit or fewer away means mobile and anything else lies near base
   wire [2:0]  orig_diff = presync_bits ^ `MSC_ORIG_MOBILE;
   wire        orig_near = ~((orig_diff[0] & orig_diff[1]) |
                             (orig_diff[0] & orig_diff[2]) |
                             (orig_diff[1] & orig_diff[2]));
   wire        orig_upd  = ~tx_mode & task_done &
                  ((done_task == `MSC_TASK_SFS) | (done_task == `MSC_TASK_SFH));
   // fec masks, rows 0..3 map to nibble bits 3..0
   wire [31:0] rows = {`MSC_FEC_ROW0, `MSC_FEC_ROW1, `MSC_FEC_ROW2, `MSC_FEC_ROW3};
   wire [3:0]  fec_par;
   wire [3:0]  syn;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_fec
         // transmit parity and receive syndrome per row
         // row g feeds nibble bit 3-g, first row in the msb
         assign fec_par[3-g] = ^(fec_tx_byte & rows[31-8*g -: 8]);
         assign syn[3-g] = ^({fec_rx_word[11:4] & rows[31-8*g -: 8],
                              fec_rx_word[3:0] & (4'h8 >> g)});
      end
   endgenerate

   // crc next value over a byte, lsb first
   function [15:0] crc_step;
      input [15:0] c;
      input [7:0]  d;
      integer i;
      reg [15:0] t;
      begin
         t = c;
         // data enters lsb first against the msb feedback tap
         for (i = 0; i < 8; i = i + 1) begin
            if (t[15] ^ d[i]) begin
               t = {t[14:0], 1'b0} ^ `MSC_CRC_POLY;
            end else begin
               t = {t[14:0], 1'b0};
            end
         end
         crc_step = t;
      end
   endfunction

   // single-bit correction: column match of syndrome
   reg [7:0] corr_mask;
   reg       corr_hit;
   integer   k;
   always @* begin
      corr_mask = 8'h00;
      corr_hit  = (syn == 4'h0);
      // hazard: two errors may alias onto a column and be miscorrected
      for (k = 0; k < 8; k = k + 1) begin
         // column of data bit 7-k across the four check rows
         if (syn == {rows[31-k], rows[23-k], rows[15-k], rows[7-k]}) begin
            corr_mask[7-k] = 1'b1;
            corr_hit = 1'b1;
         end
      end
      // a lone check-bit error leaves the data byte as it is
      if ((syn == 4'h8) | (syn == 4'h4) | (syn == 4'h2) | (syn == 4'h1)) begin
         corr_hit = 1'b1;  // error in fec nibble only
      end
   end

   // apb answers in the access cycle; with no wait states, read side
   // effects and write effects both land on the access edge
   assign pready  = 1'b1;
   // unmapped offsets read zero and ignore writes, never an error
   assign pslverr = 1'b0;
   // interrupt flag and the low bits of the last task go straight out
   assign irq_flag = irq_reg;
   assign current_task = task_reg[2:0];

   // mode and command registers
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= `MSC_MODE_RESET;
         task_reg <= `MSC_TASK_NULL;
      end else begin
         if (wr_mode) begin
            // mode byte kept whole; only three bits matter here
            mode_reg <= pwdata[7:0];
         end
         if (wr_cmd) begin
            // every task code is kept, null and reset too
            task_reg <= wtask;
         end
      end
   end

   // status flags
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_reg  <= 1'b0;
         ibe_reg  <= 1'b1;
         ovf_reg  <= 1'b0;
         chk_reg  <= 1'b0;
         qrdy_reg <= 1'b0;
         orig_reg <= 1'b0;
      end else begin
         // interleave empty: set beats clear
         if (tx_mode & tx_buffer_low) begin
            // buffer ran low while sending
            ibe_reg <= 1'b1;
         end else if (flush) begin
            // reset task or mode change, no interrupt
            ibe_reg <= 1'b1;
         end else if (real_task) begin
            // null and sync-output tasks leave it alone; the reset task sets it
            ibe_reg <= 1'b0;
         end
         // overflow: set beats read clear; a flush in the same cycle wins
         if (~tx_mode & rx_task_late & ~flush) begin
            // task came too late for gapless reception
            ovf_reg <= 1'b1;
         end else if (rd_stat | flush) begin
            // reported once, then gone
            ovf_reg <= 1'b0;
         end
         // check error: last crc or head check holds until flushed
         if (flush) begin
            chk_reg <= 1'b0;
         end else if (~tx_mode & crc_check) begin
            // compare against the inverted running crc
            chk_reg <= (crc_received != ~crc_reg);
         end else if (~tx_mode & head_check_done) begin
            // head bytes: uncorrectable fec word seen last
            chk_reg <= fec_rx_error;
         end
         // quality ready
         if (qual_done | (mode_to0 | rst_task)) begin
            // after a reset task or a mode change to zero the quality value is stale; host must ignore it
            qrdy_reg <= 1'b1;
         end else if (rd_qual) begin
            qrdy_reg <= 1'b0;
         end
         // origin from the presync bits, one error tolerated
         if (orig_upd) begin
            orig_reg <= orig_near;
         end
         // interrupt: new events win over the read clear
         // empty flag interrupts only on its rise, never on a flush
         if ((tx_mode & tx_buffer_low & ~ibe_reg) |
             (~tx_mode & rx_task_late & ~flush) |
             (qual_done & mode_reg[`MSC_MD_QIEN])) begin
            irq_reg <= 1'b1;
         end else if (rd_stat) begin
            irq_reg <= 1'b0;
         end
      end
   end

   // quality measurement over a window of bits
   // held at zero in transmit, so a return to receive starts afresh
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         qcnt_reg <= 8'h00;
         qacc_reg <= 8'h00;
         qual_reg <= 8'h00;
      end else if (meas_restart | flush | tx_mode) begin
         // realign the window; the last reading is kept
         qcnt_reg <= 8'h00;
         qacc_reg <= 8'h00;
      end else if (rx_bit_strobe) begin
         if (qual_done) begin
            // window full: load the count including this bit
            qual_reg <= qacc_reg + {7'h00, rx_bit_good};
            qcnt_reg <= 8'h00;
            qacc_reg <= 8'h00;
         end else begin
            // one more bit seen, counted if its crossing was good
            qcnt_reg <= qcnt_reg + 8'h01;
            qacc_reg <= qacc_reg + {7'h00, rx_bit_good};
         end
      end
   end

   // crc engine and fec outputs
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         crc_reg       <= `MSC_CRC_INIT;
         crc_cnt_reg   <= 5'h00;
         crc_out       <= 16'h0000;
         fec_tx_nibble <= 4'h0;
         fec_rx_byte   <= 8'h00;
         fec_rx_error  <= 1'b0;
      end else begin
         if (crc_start) begin
            // preset to all ones at block start
            crc_reg     <= `MSC_CRC_INIT;
            crc_cnt_reg <= 5'h00;
         end else if (crc_byte_valid & (crc_cnt_reg != `MSC_BLOCK_BYTES)) begin
            // bytes past the last data byte are ignored
            crc_reg     <= crc_step(crc_reg, crc_byte);
            crc_cnt_reg <= crc_cnt_reg + 5'h01;
         end
         // inverted value follows one cycle behind the running crc
         crc_out       <= ~crc_reg;
         // check nibble for the byte now on the transmit input
         fec_tx_nibble <= fec_par;
         if (fec_rx_valid) begin
            // corrected byte and its error verdict leave together
            fec_rx_byte  <= fec_rx_word[11:4] ^ corr_mask;
            fec_rx_error <= ~corr_hit;
         end
      end
   end

   // read mux
   always @* begin
      prdata = 32'h0000_0000;
      // only the addressed register drives the low bits
      case (paddr)
         `MSC_OFF_STATUS: begin
            // receive-only flags read zero while transmitting
            prdata[`MSC_ST_IRQ]  = irq_reg;
            prdata[`MSC_ST_IBE]  = ibe_reg & tx_mode;
            prdata[`MSC_ST_OVF]  = ovf_reg & ~tx_mode;
            prdata[`MSC_ST_CHK]  = chk_reg & ~tx_mode;
            prdata[`MSC_ST_QRDY] = qrdy_reg;
            prdata[`MSC_ST_ORIG] = orig_reg & ~tx_mode;
            prdata[0]            = 1'b0;
         end
         `MSC_OFF_QUALITY: prdata[7:0] = tx_mode ? 8'h00 : qual_reg;
         `MSC_OFF_MODE:    prdata[7:0] = mode_reg;
         `MSC_OFF_COMMAND: prdata[3:0] = task_reg;
         // live crc and syndrome of the word now on fec_rx_word, for software checks
         `MSC_OFF_CRC:     prdata[15:0] = crc_reg;
         `MSC_OFF_FEC:     prdata[3:0] = syn;
         default:          prdata = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// *** dv/msc_host_model.sv ***
// apb master standing in for the host controller
// assumes an apb slave on the same clock that may add wait states
`timescale 1ns/1ps
`default_nettype none
module msc_host_model (
   // clock and slave answer
   input  wire logic        clock,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   // request
   output var logic         psel,
   output var logic         penable,
   output var logic         pwrite,
   output var logic [11:0]  paddr,
   output var logic [31:0]  pwdata
);
   int hang = 0; // transfers that never saw pready
   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // one transfer; request held until pready is sampled high, or dropped after 64 cycles without it
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1 && ++n < 64);
      if (n >= 64) hang++;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** dv/msc_status_crc_fec_monitor.sv ***
// port checker for the status, crc and fec block
// assumes the apb map and field positions of msc_regs.vh
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.vh"
module msc_status_crc_fec_monitor (
   input wire logic        clock, resetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr, fec_rx_word,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        tx_buffer_low, rx_task_late, task_done, rx_bit_strobe,
   input wire logic        crc_start, fec_rx_valid, fec_rx_error, irq_flag,
   input wire logic [7:0]  fec_tx_byte, fec_rx_byte,
   input wire logic [3:0]  fec_tx_nibble,
   input wire logic [15:0] crc_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic      tx_q; // transmit mode as last written
   wire       acc = psel && penable;
   wire       rd_st = psel && !pwrite && paddr == `MSC_OFF_STATUS;
   wire       rd_q = psel && !pwrite && paddr == `MSC_OFF_QUALITY;
   wire [7:0] rx_data = fec_rx_word[11:4]; // data part, earliest bit first
   wire       quiet = !tx_buffer_low && !rx_task_late && !task_done && !rx_bit_strobe;
   // follow mode writes
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) tx_q <= 1'b0;
      else if (acc && pwrite && paddr == `MSC_OFF_MODE) tx_q <= pwdata[`MSC_MD_TXRX];
   end
   function automatic logic [3:0] fec4(input logic [7:0] b);
      return {^(b & 8'hEC), ^(b & 8'hD3), ^(b & 8'hBA), ^(b & 8'h75)};
   endfunction
   AST_NO_WAIT: assert property (acc |-> pready && !pslverr)
      else $error("apb wait or error seen");
   AST_BIT0: assert property (rd_st |-> !prdata[0] && prdata[7] == irq_flag)
      else $error("status bit 0 or irq bit wrong");
   AST_TX_ZERO: assert property (rd_st && tx_q |-> prdata[4:3] == 2'b00 && !prdata[1])
      else $error("receive flags set in transmit");
   AST_RX_EMPTY: assert property (rd_st && !tx_q |-> !prdata[5])
      else $error("empty flag set in receive");
   AST_QUAL_TX: assert property (rd_q && tx_q |-> prdata == 32'h00000000)
      else $error("quality nonzero in transmit");
   AST_IRQ_CLR: assert property (acc && rd_st && quiet |=> !irq_flag)
      else $error("irq not cleared by status read");
   AST_LATE_IRQ: assert property (rx_task_late && !tx_q |=> irq_flag)
      else $error("late task raised no irq");
   AST_FEC_TX: assert property (1'b1 |=> fec_tx_nibble == fec4($past(fec_tx_byte)))
      else $error("fec nibble wrong");
   AST_FEC_RX: assert property (fec_rx_valid && fec_rx_word[3:0] == fec4(rx_data)
      |=> fec_rx_byte == $past(rx_data) && !fec_rx_error)
      else $error("clean word altered");
   AST_CRC_PRESET: assert property (crc_start |-> ##[1:2] crc_out == 16'h0000)
      else $error("crc not preset");
endmodule
bind msc_status_crc_fec msc_status_crc_fec_monitor mon (.clock, .resetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .fec_rx_word, .pwdata, .prdata, .tx_buffer_low,
   .rx_task_late, .task_done, .rx_bit_strobe, .crc_start, .fec_rx_valid, .fec_rx_error,
   .irq_flag, .fec_tx_byte, .fec_rx_byte, .fec_tx_nibble, .crc_out);
`default_nettype wire

// *** dv/msc_status_crc_fec_tb.sv ***
// self-checking bench for the status, crc and fec block
// assumes the host model as apb master; the bench drives the core events
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.vh"
module msc_status_crc_fec_tb;
   logic clock = 1'b0, resetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq_flag;
   logic tx_buffer_low = 0, rx_task_late = 0, task_done = 0, head_check_done = 0;
   logic rx_bit_strobe = 0, rx_bit_good = 0, crc_byte_valid = 0, crc_start = 0;
   logic crc_check = 0, fec_rx_valid = 0, fec_rx_error;
   logic [3:0]  done_task = 4'h0, fec_tx_nibble;
   logic [2:0]  presync_bits = 3'h0, current_task;
   logic [7:0]  crc_byte = 8'h00, fec_tx_byte = 8'h00, fec_rx_byte;
   logic [11:0] paddr, fec_rx_word = 12'h000;
   logic [15:0] crc_received = 16'h0000, crc_out;
   logic [31:0] pwdata, prdata, rdv;
   int          err_count = 0, checks_done = 0;
   msc_status_crc_fec #(.QUAL_BITS(8)) dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .tx_buffer_low, .rx_task_late, .task_done,
      .done_task, .head_check_done, .presync_bits, .rx_bit_strobe, .rx_bit_good,
      .crc_byte_valid, .crc_byte, .crc_start, .crc_check, .crc_received, .fec_tx_byte,
      .fec_rx_word, .fec_rx_valid, .fec_tx_nibble, .fec_rx_byte, .fec_rx_error, .crc_out,
      .current_task, .irq_flag);
   msc_host_model host (.clock, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
   initial forever #20 clock = ~clock;
   task automatic chk(input string what, input logic [15:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      err_count += host.hang;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, {24'h0, d}, rdv);
      if (host.hang) give_verdict();
   endtask
   task automatic rchk(input logic [11:0] a, input logic [15:0] m, e);
      host.xfer(1'b0, a, 32'h0, rdv);
      if (host.hang) give_verdict();
      else if (m != 16'h0000) chk($sformatf("reg %h", a), e, rdv[15:0] & m);
   endtask
   task automatic st(input logic [15:0] m, e);
      rchk(`MSC_OFF_STATUS, m, e);
   endtask
   task automatic cmd(input logic [3:0] c);
      wr(`MSC_OFF_COMMAND, {4'h0, c});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   function automatic logic [3:0] fec(input logic [7:0] b);
      return {^(b & 8'hEC), ^(b & 8'hD3), ^(b & 8'hBA), ^(b & 8'h75)};
   endfunction
   task automatic t_tx();
      st(16'hFFBF, 16'h0000);
      rchk(12'h018, 16'hFFFF, 16'h0000);
      wr(`MSC_OFF_MODE, 8'h20);
      st(16'h00A0, 16'h0020);
      cmd(`MSC_TASK_TDB);
      st(16'h0020, 16'h0000);
      chk("task", {12'h0, `MSC_TASK_TDB}, {13'h0, current_task});
      @(posedge clock) tx_buffer_low <= 1'b1;
      @(posedge clock) tx_buffer_low <= 1'b0;
      tick(1);
      chk("irq", 16'h0001, {15'h0, irq_flag});
      st(16'h00A0, 16'h00A0);
      st(16'h0080, 16'h0000);
      cmd(`MSC_TASK_NULL);
      cmd(`MSC_TASK_TSO);
      st(16'h0020, 16'h0020);
      cmd(`MSC_TASK_T7H);
      st(16'h0020, 16'h0000);
      cmd(`MSC_TASK_RESET);
      st(16'h00A0, 16'h0020);
      rchk(`MSC_OFF_QUALITY, 16'hFFFF, 16'h0000);
      $display("test transmit flags done");
   endtask
   task automatic t_ovf();
      wr(`MSC_OFF_MODE, 8'h00);
      st(16'h0020, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock) rx_task_late <= 1'b1;
         @(posedge clock) rx_task_late <= 1'b0;
         if (i == 0) st(16'h0098, 16'h0090);
         if (i == 1) cmd(`MSC_TASK_RESET);
         if (i == 2) wr(`MSC_OFF_MODE, 8'h08);
         st(16'h0010, 16'h0000);
      end
      $display("test overflow done");
   endtask
   task automatic t_qual();
      wr(`MSC_OFF_MODE, 8'h04);
      st(16'h0004, 16'h0004);
      rchk(`MSC_OFF_QUALITY, 16'h0000, 16'h0000);
      st(16'h0000, 16'h0000);
      for (int i = 0; i < 11; i++) begin
         if (i == 3) begin
            @(posedge clock) begin
               task_done <= 1'b1;
               done_task <= `MSC_TASK_SFS;
               presync_bits <= 3'b011;
            end
            @(posedge clock) task_done <= 1'b0;
         end
         @(posedge clock) begin
            rx_bit_strobe <= 1'b1;
            rx_bit_good <= (i < 5);
         end
         @(posedge clock) rx_bit_strobe <= 1'b0;
      end
      tick(3);
      chk("irq", 16'h0001, {15'h0, irq_flag});
      st(16'h0006, 16'h0006);
      rchk(`MSC_OFF_QUALITY, 16'h00FF, 16'h0002);
      st(16'h0004, 16'h0000);
      $display("test quality done");
   endtask
   task automatic t_origin();
      for (int p = 0; p < 8; p++) begin
         @(posedge clock) begin
            task_done <= 1'b1;
            presync_bits <= p[2:0];
            done_task <= p[0] ? `MSC_TASK_SFH : `MSC_TASK_SFS;
         end
         @(posedge clock) task_done <= 1'b0;
         st(16'h0002, {14'h0, $countones(p[2:0] ^ 3'b011) < 2, 1'b0});
      end
      $display("test origin done");
   endtask
   task automatic t_crc();
      logic [15:0] c;
      logic [7:0]  b;
      c = 16'hFFFF;
      @(posedge clock) crc_start <= 1'b1;
      @(posedge clock) crc_start <= 1'b0;
      for (int i = 0; i < 18; i++) begin
         b = 8'(i * 29 + 49);
         @(posedge clock) begin
            crc_byte_valid <= 1'b1;
            crc_byte <= b;
         end
         for (int k = 0; k < 8; k++) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0);
      end
      @(posedge clock) crc_byte_valid <= 1'b0;
      tick(2);
      chk("crc", ~c, crc_out);
      for (int j = 0; j < 2; j++) begin
         @(posedge clock) begin
            crc_received <= ~c ^ (j ? 16'h0100 : 16'h0000);
            crc_check <= 1'b1;
         end
         @(posedge clock) crc_check <= 1'b0;
         st(16'h0008, j ? 16'h0008 : 16'h0000);
      end
      cmd(`MSC_TASK_RESET);
      st(16'h0008, 16'h0000);
      $display("test crc done");
   endtask
   task automatic fec_rx(input logic [11:0] w);
      @(posedge clock) begin
         fec_rx_word <= w;
         fec_rx_valid <= 1'b1;
      end
      @(posedge clock) fec_rx_valid <= 1'b0;
      tick(1);
   endtask
   task automatic t_fec();
      logic [7:0] b;
      for (int i = 0; i < 16; i++) begin
         b = 8'h2C ^ 8'(i * 17);
         @(posedge clock) fec_tx_byte <= b;
         tick(2);
         chk("fec nibble", {12'h0, fec(b)}, {12'h0, fec_tx_nibble});
         for (int k = 0; k < 13; k++) begin
            fec_rx({b, fec(b)} ^ (12'h001 << k));
            chk("fec byte", {8'h0, b}, {8'h0, fec_rx_byte});
            chk("fec error", 16'h0000, {15'h0, fec_rx_error});
         end
      end
      fec_rx({b, fec(b)} ^ 12'h00C);
      chk("fec error", 16'h0001, {15'h0, fec_rx_error});
      @(posedge clock) head_check_done <= 1'b1;
      @(posedge clock) head_check_done <= 1'b0;
      st(16'h0008, 16'h0008);
      wr(`MSC_OFF_MODE, 8'h08);
      st(16'h0008, 16'h0000);
      $display("test fec done");
   endtask
   initial begin
      tick(10);
      resetn <= 1'b1;
      t_tx();
      t_ovf();
      t_qual();
      t_origin();
      t_crc();
      t_fec();
      give_verdict();
   end
endmodule
`default_nettype wire
